// ---- hdl/ea_adjust.sv ----
// Final address shaping: even alignment and normal-mode truncation.
// Assumes it is purely combinational and fed from the main generator.
`timescale 1ns/1ns
module ea_adjust
(
	input  wire logic [31:0] raw_i,        // Computed address
	input  wire logic        force_even_i, // Word, long or branch target
	input  wire logic        normal_mode_i,// Sixteen-bit address space
	output logic      [31:0] addr_o        // Shaped address
);

	// ************************************************************
	// Shaping
	// ************************************************************
	// Alignment first, then width, order is irrelevant as masks commute
	always_comb
	begin
		addr_o = raw_i;
		if (force_even_i)
		begin
			addr_o = addr_o & ea_gen_pkg::EVEN_MASK;
		end
		if (normal_mode_i)
		begin
			addr_o = addr_o & ea_gen_pkg::NORMAL_MASK;
		end
	end

endmodule // ea_adjust

// ---- hdl/ea_gen_pkg.sv ----
// Constants and carrier types for the effective address generator.
// Assumes a single core clock and an instruction decoder that presents one
// request per cycle with all operand fields already extracted.
package ea_gen_pkg;

	// ************************************************************
	// Widths and address constants
	// ************************************************************
	localparam int unsigned ADDR_W        = 32;        // Full address width
	localparam int unsigned PC_W          = 24;        // Program counter width
	localparam int unsigned NORMAL_W      = 16;        // Normal mode address width
	localparam int unsigned IMM_BIT_W     = 3;         // Bit number field
	localparam int unsigned IMM_TRAP_W    = 2;         // Trap vector field
	localparam logic [31:0] RESET_ADDR    = 32'h0000_0000;
	localparam logic [2:0]  STEP_BYTE     = 3'h1;      // Pointer step per size
	localparam logic [2:0]  STEP_WORD     = 3'h2;
	localparam logic [2:0]  STEP_LONG     = 3'h4;
	localparam logic [31:0] SHORT_FILL    = 32'hffff_ff00; // Upper ones for 8-bit
	localparam logic [31:0] PC_MASK       = 32'h00ff_ffff; // Keep low 24 bits
	localparam logic [31:0] NORMAL_MASK   = 32'h0000_ffff; // Keep low 16 bits
	localparam logic [31:0] PTR_HI_MASK   = 32'h00ff_ffff; // Drop pointer first byte
	localparam logic [31:0] EVEN_MASK     = 32'hffff_fffe; // Clear bit 0

	// ************************************************************
	// Enumerations
	// ************************************************************
	// Addressing modes presented by the decoder
	typedef enum logic [3:0] {
		MODE_REG_IND   = 4'h0,
		MODE_DISP16    = 4'h1,
		MODE_DISP32    = 4'h2,
		MODE_POST_INC  = 4'h3,
		MODE_PRE_DEC   = 4'h4,
		MODE_ABS8      = 4'h5,
		MODE_ABS16     = 4'h6,
		MODE_ABS24     = 4'h7,
		MODE_ABS32     = 4'h8,
		MODE_IMM8      = 4'h9,
		MODE_IMM16     = 4'ha,
		MODE_IMM32     = 4'hb,
		MODE_IMM_BIT   = 4'hc,
		MODE_IMM_TRAP  = 4'hd,
		MODE_PC_REL8   = 4'he,
		MODE_PC_REL16  = 4'hf
	} addr_mode_type;

	// Access width
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_LONG = 2'h2
	} access_size_type;

	// Sequencer states, Gray coded along the indirect path
	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_PTR_WAIT = 2'b01
	} ea_state_type;

	// ************************************************************
	// Carrier structs
	// ************************************************************
	// Request from the instruction decoder
	typedef struct packed {
		logic            valid;    // One-cycle request strobe
		addr_mode_type   mode;     // Addressing mode
		logic            indirect; // Memory indirect jump or call
		logic            branch;   // Result is a branch target
		access_size_type size;     // Operand size
		logic [2:0]      reg_sel;  // Address register number
		logic [31:0]     ext;      // Extension word: address, disp or immediate
		logic [31:0]     pc_next;  // Address of next instruction
	} ea_req_type;

	// Answer toward the memory access sequencer
	typedef struct packed {
		logic        valid;     // One-cycle answer strobe
		logic        is_imm;    // Value is an immediate operand
		logic [31:0] value;     // Address or immediate
		logic        wb_en;     // Pointer write-back strobe
		logic [2:0]  wb_reg;    // Register written back
		logic [31:0] wb_value;  // Updated pointer
	} ea_rsp_type;

	// Pointer fetch for memory indirect mode
	typedef struct packed {
		logic        req;       // One-cycle fetch strobe
		logic        long;      // Longword in advanced mode, word in normal
		logic [31:0] addr;      // Pointer location, 0 to 255
	} ptr_fetch_type;

endpackage

// ---- hdl/effective_address_generator.sv ----
// Effective address generator of the core: one request in, one answer out.
// Assumes the decoder holds off a new request while busy_o is high and
// that the sequencer returns the indirect pointer with ptr_valid_i.
//
// Behaviour
// - Post-increment: use pointer, then add size
// - Pre-decrement: subtract size, use and store
// - Eight-bit absolute fills upper bits ones
// - Sixteen-bit absolute is sign extended
// - Thirty-two-bit absolute passes unmodified
// - Twenty-four-bit absolute: upper byte zero
// - Immediates: 8/16/32, bit 3, trap 2
// - Branch: sign-extend displacement, keep 24 bits
// - Branch base is next instruction address
// - Indirect pointer location zero-extended, 0-255
// - Normal word pointer, advanced long, top zero
// - Odd word, long or branch address even
// - Normal mode keeps low sixteen bits
// - Displacement mode adds sign-extended disp16 or disp32
// - Address width mode from sampled mode pins
`timescale 1ns/1ns
module effective_address_generator
#(
	parameter int unsigned NUM_REGS = 8  // Extended address registers
)
(
	input  wire logic                       core_clk_i,     // 20 MHz core clock
	input  wire logic                       reset_n_i,      // Async reset, low
	input  wire logic                       advanced_mode_i,// Mode pin: 1 advanced
	input  wire ea_gen_pkg::ea_req_type     req_i,          // Decoder request
	input  wire logic [31:0]                reg_value_i,    // Selected register
	input  wire logic                       ptr_valid_i,    // Pointer data ready
	input  wire logic [31:0]                ptr_data_i,     // Pointer data
	output ea_gen_pkg::ea_rsp_type          rsp_o,          // Answer
	output ea_gen_pkg::ptr_fetch_type       ptr_fetch_o,    // Pointer fetch
	output logic                            busy_o,         // Indirect in flight
	output logic                            advanced_q_o    // Latched mode
);

	// ************************************************************
	// Elaboration check
	// ************************************************************
	// Register field is three bits wide, more registers cannot be named
	if (NUM_REGS < 1 || NUM_REGS > 8)
	begin : g_bad_regs
		$error("NUM_REGS must be between 1 and 8");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic                       busy;      // Pointer fetch pending
		logic                       mode_taken;// Mode sampled once
		logic                       advanced;  // Advanced mode latch
		ea_gen_pkg::ea_state_type   state;     // Sequencer state
		ea_gen_pkg::ea_rsp_type     rsp;       // Registered answer
		ea_gen_pkg::ptr_fetch_type  fetch;     // Registered fetch
	} ea_regs_type;

	ea_regs_type regs_q;   // Current state
	ea_regs_type regs_d;   // Next state
	logic [1:0]  rst_sync_q; // Reset release pipe, raw reset domain
	logic        rst_n;    // Synchronised reset
	logic [31:0] raw_addr; // Address before shaping
	logic [31:0] shaped;   // Address after shaping
	logic        force_even;
	logic        addr_norm;
	logic [31:0] wb_next;  // Pointer update
	logic        is_imm;

	// ************************************************************
	// Helpers
	// ************************************************************
	// Pointer step for an access size
	function automatic logic [31:0] step_of(input ea_gen_pkg::access_size_type s);
		logic [2:0] st;
		st = ea_gen_pkg::STEP_BYTE;
		unique case (s)
			ea_gen_pkg::SIZE_WORD: st = ea_gen_pkg::STEP_WORD;
			ea_gen_pkg::SIZE_LONG: st = ea_gen_pkg::STEP_LONG;
			default:               st = ea_gen_pkg::STEP_BYTE;
		endcase
		return {29'h0, st};
	endfunction

	// Sign extension of a sixteen-bit field
	function automatic logic [31:0] sext16(input logic [31:0] v);
		return {{16{v[15]}}, v[15:0]};
	endfunction

	// ************************************************************
	// Reset release
	// ************************************************************
	// Two-stage release so all state leaves reset on the same edge
	// Kept outside the state struct: only this pipe sees the raw pin
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_sync_q <= 2'h0;
		end
		else
		begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ************************************************************
	// Address arithmetic
	// ************************************************************
	// Computes the raw address or immediate for the current request
	always_comb
	begin
		raw_addr   = reg_value_i;
		wb_next    = reg_value_i;
		is_imm     = 1'b0;
		force_even = (req_i.size != ea_gen_pkg::SIZE_BYTE) | req_i.branch;
		unique case (req_i.mode)
			ea_gen_pkg::MODE_REG_IND: raw_addr = reg_value_i;
			ea_gen_pkg::MODE_DISP16:  raw_addr = reg_value_i + sext16(req_i.ext);
			ea_gen_pkg::MODE_DISP32:  raw_addr = reg_value_i + req_i.ext;
			ea_gen_pkg::MODE_POST_INC:
			begin
				raw_addr = reg_value_i;
				wb_next  = reg_value_i + step_of(req_i.size);
			end
			ea_gen_pkg::MODE_PRE_DEC:
			begin
				raw_addr = reg_value_i - step_of(req_i.size);
				wb_next  = raw_addr;
			end
			ea_gen_pkg::MODE_ABS8:  raw_addr = ea_gen_pkg::SHORT_FILL | {24'h0, req_i.ext[7:0]};
			ea_gen_pkg::MODE_ABS16: raw_addr = sext16(req_i.ext);
			ea_gen_pkg::MODE_ABS24: raw_addr = req_i.ext & ea_gen_pkg::PC_MASK;
			ea_gen_pkg::MODE_ABS32: raw_addr = req_i.ext;
			ea_gen_pkg::MODE_IMM8:
			begin
				raw_addr = {24'h0, req_i.ext[7:0]};
				is_imm   = 1'b1;
			end
			ea_gen_pkg::MODE_IMM16:
			begin
				raw_addr = {16'h0, req_i.ext[15:0]};
				is_imm   = 1'b1;
			end
			ea_gen_pkg::MODE_IMM32:
			begin
				raw_addr = req_i.ext;
				is_imm   = 1'b1;
			end
			ea_gen_pkg::MODE_IMM_BIT:
			begin
				raw_addr = {29'h0, req_i.ext[ea_gen_pkg::IMM_BIT_W-1:0]};
				is_imm   = 1'b1;
			end
			ea_gen_pkg::MODE_IMM_TRAP:
			begin
				raw_addr = {30'h0, req_i.ext[ea_gen_pkg::IMM_TRAP_W-1:0]};
				is_imm   = 1'b1;
			end
			ea_gen_pkg::MODE_PC_REL8:
			begin
				raw_addr = (req_i.pc_next + {{24{req_i.ext[7]}}, req_i.ext[7:0]})
					& ea_gen_pkg::PC_MASK;
				force_even = 1'b1;
			end
			ea_gen_pkg::MODE_PC_REL16:
			begin
				raw_addr = (req_i.pc_next + sext16(req_i.ext)) & ea_gen_pkg::PC_MASK;
				force_even = 1'b1;
			end
		endcase
		// Immediates are values, never aligned or truncated
		if (is_imm)
		begin
			force_even = 1'b0;
		end
		addr_norm = ~regs_q.advanced & ~is_imm;
	end

	// Even alignment and normal-mode truncation
	ea_adjust u_adjust
	(
		.raw_i         (raw_addr),
		.force_even_i  (force_even),
		.normal_mode_i (addr_norm),
		.addr_o        (shaped)
	);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb
	begin
		regs_d           = regs_q;
		regs_d.rsp.valid = 1'b0;
		regs_d.rsp.wb_en = 1'b0;
		regs_d.fetch.req = 1'b0;
		// mode pins sampled after reset release
		if (!regs_q.mode_taken)
		begin
			regs_d.mode_taken = 1'b1;
			regs_d.advanced   = advanced_mode_i;
		end
		unique case (regs_q.state)
			ea_gen_pkg::ST_IDLE:
			begin
				if (req_i.valid && regs_q.mode_taken)
				begin
					if (req_i.indirect)
					begin
						regs_d.fetch.addr = {24'h0, req_i.ext[7:0]};
						// word in normal, long in advanced
						regs_d.fetch.long = regs_q.advanced;
						regs_d.fetch.req  = 1'b1;
						regs_d.state      = ea_gen_pkg::ST_PTR_WAIT;
					end
					else
					begin
						regs_d.rsp.valid    = 1'b1;
						regs_d.rsp.is_imm   = is_imm;
						regs_d.rsp.value    = shaped;
						regs_d.rsp.wb_reg   = req_i.reg_sel;
						regs_d.rsp.wb_en    = (req_i.mode == ea_gen_pkg::MODE_POST_INC) |
							(req_i.mode == ea_gen_pkg::MODE_PRE_DEC);
						regs_d.rsp.wb_value = addr_norm ? (wb_next & ea_gen_pkg::NORMAL_MASK)
							: wb_next;
					end
				end
			end
			ea_gen_pkg::ST_PTR_WAIT:
			begin
				if (ptr_valid_i)
				begin
					regs_d.rsp.valid  = 1'b1;
					regs_d.rsp.is_imm = 1'b0;
					regs_d.rsp.value  = regs_q.advanced
						? (ptr_data_i & ea_gen_pkg::PTR_HI_MASK & ea_gen_pkg::EVEN_MASK)
						: (ptr_data_i & ea_gen_pkg::NORMAL_MASK & ea_gen_pkg::EVEN_MASK);
					regs_d.state      = ea_gen_pkg::ST_IDLE;
				end
			end
			default: regs_d.state = ea_gen_pkg::ST_IDLE;
		endcase
		// Busy is registered on its own so the pin comes from a flop
		regs_d.busy = (regs_d.state != ea_gen_pkg::ST_IDLE);
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Reset values are constants only; mode is captured after release
	// Runs on the synchronised reset, so release is clean on every field
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			regs_q.busy       <= 1'b0;
			regs_q.mode_taken <= 1'b0;
			regs_q.advanced   <= 1'b0;
			regs_q.state      <= ea_gen_pkg::ST_IDLE;
			regs_q.rsp        <= '0;
			regs_q.fetch      <= '0;
		end
		else
		begin
			regs_q.busy       <= regs_d.busy;
			regs_q.mode_taken <= regs_d.mode_taken;
			regs_q.advanced   <= regs_d.advanced;
			regs_q.state      <= regs_d.state;
			regs_q.rsp        <= regs_d.rsp;
			regs_q.fetch      <= regs_d.fetch;
		end
	end

	// ************************************************************
	// Outputs straight from flip-flops
	// ************************************************************
	assign rsp_o        = regs_q.rsp;
	assign ptr_fetch_o  = regs_q.fetch;
	assign busy_o       = regs_q.busy;
	assign advanced_q_o = regs_q.advanced;

endmodule // effective_address_generator

// ---- sim/ea_expect.svh ----
// Reference operand address and pointer update for the checker and the bench.
// Assumes inclusion inside a module body; holds no state.
function automatic logic [31:0] ea_step(ea_gen_pkg::access_size_type s);
	return (s == ea_gen_pkg::SIZE_BYTE) ? 32'h1 : (s == ea_gen_pkg::SIZE_WORD) ? 32'h2 : 32'h4;
endfunction
// Pointer after the access; never aligned, cut to 16 bits in normal mode
function automatic logic [31:0] ea_wb(ea_gen_pkg::ea_req_type q, logic [31:0] r, logic a);
	logic [31:0] v;
	v = (q.mode == ea_gen_pkg::MODE_PRE_DEC) ? r - ea_step(q.size) : r + ea_step(q.size);
	return a ? v : v & 32'h0000ffff;
endfunction
// Address or immediate for one direct request
function automatic logic [31:0] ea_ref(ea_gen_pkg::ea_req_type q, logic [31:0] r, logic a);
	logic [31:0] v;
	logic [31:0] d8;
	logic [31:0] d16;
	d8 = {{24{q.ext[7]}}, q.ext[7:0]};
	d16 = {{16{q.ext[15]}}, q.ext[15:0]};
	case (q.mode)
		ea_gen_pkg::MODE_DISP16: v = r + d16;
		ea_gen_pkg::MODE_DISP32: v = r + q.ext;
		ea_gen_pkg::MODE_PRE_DEC: v = r - ea_step(q.size);
		ea_gen_pkg::MODE_ABS8: v = d8 | 32'hffffff00;
		ea_gen_pkg::MODE_ABS16: v = d16;
		ea_gen_pkg::MODE_ABS24: v = q.ext & 32'h00ffffff;
		ea_gen_pkg::MODE_ABS32: v = q.ext;
		ea_gen_pkg::MODE_IMM8: return q.ext & 32'h000000ff;
		ea_gen_pkg::MODE_IMM16: return q.ext & 32'h0000ffff;
		ea_gen_pkg::MODE_IMM32: return q.ext;
		ea_gen_pkg::MODE_IMM_BIT: return q.ext & 32'h00000007;
		ea_gen_pkg::MODE_IMM_TRAP: return q.ext & 32'h00000003;
		ea_gen_pkg::MODE_PC_REL8: v = (q.pc_next + d8) & 32'h00fffffe;
		ea_gen_pkg::MODE_PC_REL16: v = (q.pc_next + d16) & 32'h00fffffe;
		default: v = r;
	endcase
	if (q.size != ea_gen_pkg::SIZE_BYTE || q.branch)
		v[0] = 1'b0;
	return a ? v : v & 32'h0000ffff;
endfunction

// ---- sim/effective_address_generator_assertions.sv ----
// Checker of the effective address generator, bound to its top ports.
// Assumes requests come only once the mode pin has been sampled.
`timescale 1ns/1ns
module effective_address_generator_assertions
#(
	parameter int unsigned NUM_REGS = 8 // Register count, passed through
)
(
	input wire logic                      core_clk_i,
	input wire logic                      reset_n_i,
	input wire logic                      advanced_mode_i,
	input wire ea_gen_pkg::ea_req_type    req_i,
	input wire logic [31:0]               reg_value_i,
	input wire logic                      ptr_valid_i,
	input wire logic [31:0]               ptr_data_i,
	input wire ea_gen_pkg::ea_rsp_type    rsp_o,
	input wire ea_gen_pkg::ptr_fetch_type ptr_fetch_o,
	input wire logic                      busy_o,
	input wire logic                      advanced_q_o
);
`include "ea_expect.svh"
	logic [2:0]  up_q; // Edges since release, saturating
	logic [31:0] ev;   // Expected answer
	logic [31:0] wv;   // Expected pointer update
	logic [31:0] pv;   // Expected indirect target
	logic [7:0]  loc;  // Pointer location field
	logic        dt;   // Direct request taken
	logic        it;   // Indirect request taken
	assign ev  = ea_ref(req_i, reg_value_i, advanced_q_o);
	assign wv  = ea_wb(req_i, reg_value_i, advanced_q_o);
	assign pv  = ptr_data_i & (advanced_q_o ? 32'h00fffffe : 32'h0000fffe);
	assign loc = req_i.ext[7:0];
	assign dt  = req_i.valid && !busy_o && up_q == 3'h7 && !req_i.indirect;
	assign it  = req_i.valid && !busy_o && up_q == 3'h7 && req_i.indirect;
	// Settle counter; conservative so early refusals never confuse us
	always_ff @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_ans; rsp_o.valid && rsp_o.value == $past(ev); endsequence
	sequence s_fetch;
		ptr_fetch_o.req && busy_o && ptr_fetch_o.addr == {24'h0, $past(loc)}
			&& ptr_fetch_o.long == advanced_q_o;
	endsequence
	property p_post_inc;
		dt && req_i.mode == ea_gen_pkg::MODE_POST_INC |=> s_ans ##0 rsp_o.wb_en
			&& rsp_o.wb_value == $past(wv);
	endproperty
	property p_pre_dec;
		dt && req_i.mode == ea_gen_pkg::MODE_PRE_DEC |=> s_ans ##0 rsp_o.wb_en
			&& rsp_o.wb_value == $past(wv) && rsp_o.value[31:1] == rsp_o.wb_value[31:1];
	endproperty
	property p_abs;
		dt && req_i.mode inside {[ea_gen_pkg::MODE_ABS8 : ea_gen_pkg::MODE_ABS32]}
			|=> s_ans ##0 !rsp_o.wb_en;
	endproperty
	property p_imm;
		dt && req_i.mode inside {[ea_gen_pkg::MODE_IMM8 : ea_gen_pkg::MODE_IMM_TRAP]}
			|=> s_ans ##0 rsp_o.is_imm;
	endproperty
	property p_pc_rel;
		dt && req_i.mode inside {ea_gen_pkg::MODE_PC_REL8, ea_gen_pkg::MODE_PC_REL16} |=> s_ans;
	endproperty
	property p_disp;
		dt && req_i.mode inside {[ea_gen_pkg::MODE_REG_IND : ea_gen_pkg::MODE_DISP32]}
			|=> s_ans ##0 !rsp_o.wb_en;
	endproperty
	property p_fetch; it |=> s_fetch ##1 !ptr_fetch_o.req; endproperty
	property p_ind_ans;
		busy_o && ptr_valid_i |=> rsp_o.valid && !busy_o && rsp_o.value == $past(pv);
	endproperty
	property p_mode_hold; up_q == 3'h7 |-> $stable(advanced_q_o); endproperty
	a_post_inc: assert property (p_post_inc) else $error("post-increment answer wrong");
	a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement answer wrong");
	a_abs: assert property (p_abs) else $error("absolute address wrong");
	a_imm: assert property (p_imm) else $error("immediate wrong");
	a_pc_rel: assert property (p_pc_rel) else $error("branch target wrong");
	a_disp: assert property (p_disp) else $error("displacement sum wrong");
	a_fetch: assert property (p_fetch) else $error("pointer fetch wrong");
	a_ind_ans: assert property (p_ind_ans) else $error("indirect target wrong");
	a_mode_hold: assert property (p_mode_hold) else $error("latched mode moved");
endmodule // effective_address_generator_assertions
bind effective_address_generator effective_address_generator_assertions
	#(.NUM_REGS(NUM_REGS)) chk_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.advanced_mode_i(advanced_mode_i), .req_i(req_i), .reg_value_i(reg_value_i),
	.ptr_valid_i(ptr_valid_i), .ptr_data_i(ptr_data_i), .rsp_o(rsp_o),
	.ptr_fetch_o(ptr_fetch_o), .busy_o(busy_o), .advanced_q_o(advanced_q_o));

// ---- sim/effective_address_generator_bench.sv ----
// Self-checking bench of the effective address generator.
// Assumes the decoder forwards write-backs and keeps word and long pointers even.
`timescale 1ns/1ns
module effective_address_generator_bench;
`include "ea_expect.svh"
	logic                      core_clk = 1'b0;
	logic                      reset_n  = 1'b0;
	logic                      adv      = 1'b1;  // Mode pin
	logic                      mexp     = 1'b1;  // Mode expected latched
	logic                      pvld;
	logic [31:0]               pdat;
	logic [31:0]               regv     = 32'h0;
	logic [31:0]               pcv      = 32'h00123456;
	logic [3:0]                lag      = 4'h0;
	logic                      busy;
	logic                      advq;
	ea_gen_pkg::ea_req_type    req      = '0;
	ea_gen_pkg::ea_rsp_type    rsp;
	ea_gen_pkg::ptr_fetch_type ptr;
	int                        fail_count  = 0;
	int                        check_count = 0;
	always #25 core_clk = ~core_clk;
	effective_address_generator #(.NUM_REGS(8)) dut_u (.core_clk_i(core_clk), .reset_n_i(reset_n),
		.advanced_mode_i(adv), .req_i(req), .reg_value_i(regv), .ptr_valid_i(pvld),
		.ptr_data_i(pdat), .rsp_o(rsp), .ptr_fetch_o(ptr), .busy_o(busy), .advanced_q_o(advq));
	ptr_source_model far_u (.clk_i(core_clk), .reset_n_i(reset_n), .fetch_i(ptr), .lag_i(lag),
		.valid_o(pvld), .data_o(pdat));
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Reset, then move the pin to show the mode is latched
	task automatic do_reset(logic a);
		reset_n = 1'b0;
		adv = a;
		mexp = a;
		repeat (10) @(posedge core_clk);
		#1 reset_n = 1'b1;
		repeat (8) @(posedge core_clk);
		#1 adv = ~a;
		check({31'h0, advq}, {31'h0, a});
	endtask
	// One direct request, answer due one edge later; valid stays up
	task automatic send(ea_gen_pkg::addr_mode_type m, ea_gen_pkg::access_size_type s,
		logic [31:0] r, logic [31:0] e);
		// word and long pointers kept even
		if (m inside {ea_gen_pkg::MODE_POST_INC, ea_gen_pkg::MODE_PRE_DEC}
			&& s != ea_gen_pkg::SIZE_BYTE)
			r[0] = 1'b0;
		req = '{valid: 1'b1, mode: m, indirect: 1'b0, size: s, reg_sel: 3'h5, ext: e,
			pc_next: pcv, branch: m inside {[ea_gen_pkg::MODE_ABS24 : ea_gen_pkg::MODE_ABS24],
			ea_gen_pkg::MODE_PC_REL8, ea_gen_pkg::MODE_PC_REL16}};
		regv = r;
		@(posedge core_clk);
		#1;
		check({31'h0, rsp.valid}, 32'h1);
		check(rsp.value, ea_ref(req, r, mexp));
		check({31'h0, rsp.wb_en}, {31'h0, m inside {[3:4]}});
		check({31'h0, rsp.is_imm}, {31'h0, m inside {[9:13]}});
		if (rsp.wb_en === 1'b1)
		begin
			check(rsp.wb_value, ea_wb(req, r, mexp));
			check({29'h0, rsp.wb_reg}, 32'h5);
		end
	endtask
	task automatic idle;
		req.valid = 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	// Every mode with every size, back to back, odd pointer on purpose
	task automatic t_all;
		for (int i = 0; i < 16; i++)
			for (int k = 0; k < 3; k++)
				send(ea_gen_pkg::addr_mode_type'(i[3:0]), ea_gen_pkg::access_size_type'(k[1:0]),
					32'h12345679, 32'h89ab8081);
		idle();
	endtask
	// Branch reach ends and the 24-bit wrap
	task automatic t_pc;
		pcv = 32'h00000100;
		send(ea_gen_pkg::MODE_PC_REL8, ea_gen_pkg::SIZE_BYTE, 32'h0, 32'h80);
		check(rsp.value, 32'h00000080);
		send(ea_gen_pkg::MODE_PC_REL8, ea_gen_pkg::SIZE_BYTE, 32'h0, 32'h7f);
		check(rsp.value, 32'h0000017e);
		pcv = 32'h00fffff0;
		send(ea_gen_pkg::MODE_PC_REL16, ea_gen_pkg::SIZE_BYTE, 32'h0, 32'h7ffe);
		check(rsp.value, 32'h00007fee);
		idle();
	endtask
	// Back-to-back pointer updates with the new value forwarded
	task automatic t_b2b;
		send(ea_gen_pkg::MODE_POST_INC, ea_gen_pkg::SIZE_LONG, 32'h2000, 32'h0);
		send(ea_gen_pkg::MODE_POST_INC, ea_gen_pkg::SIZE_LONG, 32'h2004, 32'h0);
		check(rsp.value ^ rsp.wb_value, 32'h2004 ^ 32'h2008);
		send(ea_gen_pkg::MODE_PRE_DEC, ea_gen_pkg::SIZE_BYTE, 32'h10, 32'h0);
		check(rsp.value, 32'h0000000f);
		idle();
	endtask
	// Indirect jump; a request during the wait must be dropped
	task automatic t_ind(logic [3:0] l);
		logic hit;
		lag = l;
		req = '{valid: 1'b1, mode: ea_gen_pkg::MODE_REG_IND, indirect: 1'b1, branch: 1'b1,
			size: ea_gen_pkg::SIZE_LONG, reg_sel: 3'h0, ext: 32'h85, pc_next: pcv};
		@(posedge core_clk);
		#1 req.indirect = 1'b0;
		check(ptr.addr, 32'h00000085);
		check({30'h0, ptr.req, busy}, 32'h3);
		check({31'h0, ptr.long}, {31'h0, mexp});
		req.mode = ea_gen_pkg::MODE_POST_INC;
		@(posedge core_clk);
		#1 req.valid = 1'b0;
		hit = rsp.wb_en;
		for (int n = 0; n < 30 && rsp.valid !== 1'b1; n++)
		begin
			@(posedge core_clk);
			#1 hit |= rsp.wb_en;
		end
		check({31'h0, rsp.valid}, 32'h1);
		check(rsp.value, mexp ? 32'h00123084 : 32'h00003084);
		check({30'h0, busy, hit}, 32'h0);
		idle();
	endtask
	initial
	begin
		#500000 fail_count++;
		wrap_up();
	end
	initial
	begin
		do_reset(1'b1);
		t_all();
		t_pc();
		t_b2b();
		t_ind(4'h0);
		t_ind(4'h6);
		do_reset(1'b0);
		t_all();
		t_ind(4'h3);
		wrap_up();
	end
endmodule // effective_address_generator_bench

// ---- sim/ptr_source_model.sv ----
// Memory side for indirect pointer fetches, with a settable answer delay.
// Assumes one fetch in flight; data is a pattern of the pointer location.
`timescale 1ns/1ns
module ptr_source_model
(
	input  wire logic                      clk_i,     // Core clock
	input  wire logic                      reset_n_i, // Async reset, low
	input  wire ea_gen_pkg::ptr_fetch_type fetch_i,   // Fetch request
	input  wire logic [3:0]                lag_i,     // Extra wait cycles
	output logic                           valid_o,   // Pointer ready pulse
	output logic [31:0]                    data_o     // Pointer data
);
	logic [7:0] loc_q; // Requested location
	logic [4:0] cnt_q; // Cycles left to answer
	// Data toggles when not valid so nothing stale looks good
	always @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			valid_o <= 1'b0;
			data_o <= 32'h0;
			cnt_q <= 5'h0;
		end
		else
		begin
			valid_o <= 1'b0;
			data_o <= ~data_o;
			if (fetch_i.req)
			begin
				loc_q <= fetch_i.addr[7:0];
				cnt_q <= {1'b0, lag_i} + 5'h1;
			end
			else if (cnt_q == 5'h1)
			begin
				valid_o <= 1'b1;
				// First byte non-zero, so its clearing shows
				data_o <= {16'ha512, 8'h30, loc_q};
				cnt_q <= 5'h0;
			end
			else if (cnt_q != 5'h0)
				cnt_q <= cnt_q - 5'h1;
		end
endmodule // ptr_source_model
